// >>> design/clock_reset_params.svh
// Constants for the clock and reset pin control block.
// Assumes a single 10 MHz system clock; included by bare name.
`ifndef CLOCK_RESET_PARAMS_SVH
`define CLOCK_RESET_PARAMS_SVH

`define CLK_PERIOD_NS       100
`define RESET_VECTOR        20'hF_FFF0
`define PD_DELAY_DEFAULT    16
`define PD_CNT_W            16
`define ADDR_W              20

`endif

// >>> design/clock_reset_pkg.sv
// Types shared by the clock and reset pin control block.
// Assumes clock_reset_params.svh supplies the widths.
`include "clock_reset_params.svh"

package clock_reset_pkg;

    typedef enum logic [1:0]
    {
        ST_RESET   = 2'b00,
        ST_ALIGN   = 2'b01,
        ST_RUN     = 2'b10,
        ST_PD_WAIT = 2'b11
    } run_state_t;

    typedef struct packed
    {
        logic                     fetch_valid;
        logic [`ADDR_W-1:0]       fetch_addr;
    } fetch_req_t;

    typedef struct packed
    {
        logic exec_clk_en;
        logic periph_clk_en;
        logic osc_en;
    } clk_gate_t;

endpackage : clock_reset_pkg

// >>> design/sync_two_flop.sv
// Two flip-flop synchroniser for one level input.
// Assumes the input is asynchronous to clk.
`timescale 1ns/1ps

module sync_two_flop
(
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic rst_value,
    input  wire logic async_in,
    output logic      sync_out
);

    logic meta_reg;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            meta_reg <= rst_value;
            sync_out <= rst_value;
        end
        else
        begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule : sync_two_flop

// >>> design/clock_reset_pin_control.sv
// Function
// - Output reference clock runs at exactly half the input clock rate.
// - Output clock has 50% duty, toggling on each input clock falling edge.
// - Reset aborts any bus cycle in progress and initialises the device.
// - During reset all pins take defined states and reset indication asserts.
// - On reset release the output clock phase aligns before execution starts.
// - First fetch after reset goes to address 0FFFF0H.
// - Reset indication stays asserted as long as reset input is asserted.
// - Leaving powerdown waits a pin-set delay before resuming operation.
// - Crystal drive output keeps driving in pin-float test mode.
// - Powerdown stops all internal clocks at zero and disables the oscillator.
// - Idle stops execution and bus clocks at zero; peripherals keep running.
//
// Clock and reset pin control: the input clock arrives as a level, and a one-cycle enable
// derived from it marks each falling edge of the double-rate source, all on clk.
`timescale 1ns/1ps
`include "clock_reset_params.svh"

module clock_reset_pin_control
#(
    parameter int PD_DELAY = `PD_DELAY_DEFAULT
)
(
    input  wire logic                    clk,
    input  wire logic                    sys_rst,
    input  wire logic                    clock_source_in,
    input  wire logic                    reset_request_n_in,
    input  wire logic                    upper_address_test_pin,
    input  wire logic                    idle_req,
    input  wire logic                    powerdown_req,
    input  wire logic                    wake_req,
    input  wire logic                    powerdown_delay_pin,
    input  wire logic                    bus_cycle_active,
    output logic                         half_rate_clock_out,
    output logic                         crystal_drive_out,
    output logic                         crystal_drive_oe,
    output logic                         reset_indication_out,
    output logic                         pin_float_test_mode,
    output logic                         bus_abort,
    output logic                         powerdown_delay_oe,
    output clock_reset_pkg::fetch_req_t  fetch_req,
    output clock_reset_pkg::clk_gate_t   clk_gate
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic src_sync;
    logic rst_n_sync;
    logic pdt_sync;
    logic a19_sync;

    sync_two_flop u_sync_src (.clk(clk), .sys_rst(sys_rst), .rst_value(1'b1),
        .async_in(clock_source_in), .sync_out(src_sync));
    sync_two_flop u_sync_rst (.clk(clk), .sys_rst(sys_rst), .rst_value(1'b1),
        .async_in(reset_request_n_in), .sync_out(rst_n_sync));
    sync_two_flop u_sync_pdt (.clk(clk), .sys_rst(sys_rst), .rst_value(1'b1),
        .async_in(powerdown_delay_pin), .sync_out(pdt_sync));
    sync_two_flop u_sync_a19 (.clk(clk), .sys_rst(sys_rst), .rst_value(1'b1),
        .async_in(upper_address_test_pin), .sync_out(a19_sync));

    logic src_prev_reg;
    logic rst_n_prev_reg;
    logic src_fall;
    logic rst_active;
    logic rst_rise;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            // The reset pin idles high, so no false release edge follows reset.
            src_prev_reg   <= 1'b1;
            rst_n_prev_reg <= 1'b1;
        end
        else
        begin
            src_prev_reg   <= src_sync;
            rst_n_prev_reg <= rst_n_sync;
        end
    end

    assign src_fall   = src_prev_reg && !src_sync;
    assign rst_active = !rst_n_sync;
    assign rst_rise   = rst_n_sync && !rst_n_prev_reg;

    // ------------------------------------------------------------
    // Run state
    // ------------------------------------------------------------
    clock_reset_pkg::run_state_t state_reg;
    logic [`PD_CNT_W-1:0]        pd_cnt_reg;
    logic                        pd_mode_reg;

    always_ff @(posedge clk)
    begin
        if (sys_rst || rst_active)
        begin
            state_reg  <= clock_reset_pkg::ST_RESET;
            pd_cnt_reg <= '0;
        end
        else
        begin
            unique case (state_reg)
                clock_reset_pkg::ST_RESET:
                begin
                    if (rst_rise)
                        state_reg <= clock_reset_pkg::ST_ALIGN;
                end
                clock_reset_pkg::ST_ALIGN:
                begin
                    if (src_fall)
                        state_reg <= clock_reset_pkg::ST_RUN;
                end
                clock_reset_pkg::ST_RUN:
                begin
                    if (pd_mode_reg && wake_req)
                    begin
                        state_reg  <= clock_reset_pkg::ST_PD_WAIT;
                        pd_cnt_reg <= '0;
                    end
                end
                clock_reset_pkg::ST_PD_WAIT:
                begin
                    // Wait for the capacitor to charge, then the fixed count.
                    if (!pdt_sync)
                        pd_cnt_reg <= '0;
                    else if (pd_cnt_reg == PD_DELAY[`PD_CNT_W-1:0] - 1'b1)
                        state_reg <= clock_reset_pkg::ST_RUN;
                    else
                        pd_cnt_reg <= pd_cnt_reg + 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Low power modes
    // ------------------------------------------------------------
    logic idle_mode_reg;

    always_ff @(posedge clk)
    begin
        if (sys_rst || rst_active)
        begin
            pd_mode_reg   <= 1'b0;
            idle_mode_reg <= 1'b0;
        end
        else if (state_reg == clock_reset_pkg::ST_RUN)
        begin
            if (pd_mode_reg && wake_req)
                pd_mode_reg <= 1'b0;
            else if (powerdown_req)
                pd_mode_reg <= 1'b1;
            if (wake_req)
                idle_mode_reg <= 1'b0;
            else if (idle_req)
                idle_mode_reg <= 1'b1;
        end
    end

    logic running;
    assign running = (state_reg == clock_reset_pkg::ST_RUN) && !pd_mode_reg;

    // ------------------------------------------------------------
    // Half rate clock and gates
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (sys_rst || state_reg == clock_reset_pkg::ST_RESET ||
            state_reg == clock_reset_pkg::ST_ALIGN)
        begin
            half_rate_clock_out <= 1'b0;
        end
        else if (src_fall)
        begin
            half_rate_clock_out <= !half_rate_clock_out;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            clk_gate <= '0;
        end
        else
        begin
            clk_gate.exec_clk_en   <= running && !idle_mode_reg;
            clk_gate.periph_clk_en <= running;
            clk_gate.osc_en        <= !pd_mode_reg;
        end
    end

    // ------------------------------------------------------------
    // Reset indication, abort and fetch
    // ------------------------------------------------------------
    logic fetch_pending_reg;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            reset_indication_out <= 1'b1;
            bus_abort            <= 1'b0;
            fetch_pending_reg    <= 1'b0;
            fetch_req            <= '0;
        end
        else
        begin
            reset_indication_out <= rst_active;
            bus_abort            <= rst_active && bus_cycle_active;
            fetch_req.fetch_valid <= 1'b0;
            if (rst_active)
            begin
                fetch_pending_reg <= 1'b1;
                fetch_req.fetch_addr <= '0;
            end
            else if (fetch_pending_reg && running && !idle_mode_reg)
            begin
                fetch_pending_reg     <= 1'b0;
                fetch_req.fetch_valid <= 1'b1;
                fetch_req.fetch_addr  <= `RESET_VECTOR;
            end
        end
    end

    // ------------------------------------------------------------
    // Test mode and pin drives
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            pin_float_test_mode <= 1'b0;
            crystal_drive_out   <= 1'b0;
            crystal_drive_oe    <= 1'b1;
            powerdown_delay_oe  <= 1'b0;
        end
        else
        begin
            if (rst_active)
            begin
                pin_float_test_mode <= !a19_sync;
            end
            // The crystal drive follows the oscillator even in float mode.
            crystal_drive_out  <= !src_sync && !pd_mode_reg;
            crystal_drive_oe   <= 1'b1;
            powerdown_delay_oe <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    reset_ind_follow_a: assert property (@(posedge clk) disable iff (sys_rst)
        rst_active |=> reset_indication_out)
        else $error("Reset indication not asserted during reset.");
    half_clk_toggle_a: assert property (@(posedge clk) disable iff (sys_rst)
        (src_fall && running) |=> half_rate_clock_out != $past(half_rate_clock_out))
        else $error("Half rate clock did not toggle on falling edge.");
    half_clk_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        (!src_fall && state_reg == clock_reset_pkg::ST_RUN) |=> $stable(half_rate_clock_out))
        else $error("Half rate clock changed without a falling edge.");
    align_low_a: assert property (@(posedge clk) disable iff (sys_rst)
        (state_reg == clock_reset_pkg::ST_ALIGN) |=> !half_rate_clock_out)
        else $error("Half rate clock not held low while aligning.");
    fetch_vector_a: assert property (@(posedge clk) disable iff (sys_rst)
        fetch_req.fetch_valid |-> fetch_req.fetch_addr == `RESET_VECTOR)
        else $error("First fetch not at reset vector.");
    reset_state_a: assert property (@(posedge clk) disable iff (sys_rst)
        rst_active |=> state_reg == clock_reset_pkg::ST_RESET)
        else $error("Reset did not initialise state.");
    idle_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
        idle_mode_reg |=> !clk_gate.exec_clk_en)
        else $error("Execution clock running in idle.");
    pd_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
        pd_mode_reg |=> !clk_gate.osc_en && !clk_gate.periph_clk_en)
        else $error("Clocks running in powerdown.");
    osc_drive_a: assert property (@(posedge clk) disable iff (sys_rst)
        (pin_float_test_mode && !pd_mode_reg) |=>
        crystal_drive_oe && (crystal_drive_out == !$past(src_sync)))
        else $error("Crystal drive floated in test mode.");
    pd_wait_a: assert property (@(posedge clk) disable iff (sys_rst)
        (state_reg == clock_reset_pkg::ST_PD_WAIT && !pdt_sync && !rst_active)
        |=> state_reg == clock_reset_pkg::ST_PD_WAIT)
        else $error("Left powerdown before delay pin released.");
    sync_release_a: assert property (@(posedge clk) disable iff (sys_rst)
        (state_reg == clock_reset_pkg::ST_RESET && !rst_rise) |=>
        state_reg == clock_reset_pkg::ST_RESET)
        else $error("Left reset without a synchronised release.");

endmodule : clock_reset_pin_control

// >>> test/osc_reset_partner.sv
// Board oscillator, reset source and delay capacitor that face the pin control block.
// Assumes the bench clock; every pin changes just after its rising edge.
`timescale 1ns/1ps

module osc_reset_partner
#(
    parameter int SRC_HALF = 4,
    parameter int CHARGE   = 6
)
(
    input  wire logic clk,
    input  wire logic reset_cmd,
    input  wire logic test_mode_cmd,
    input  wire logic charge_en,
    output logic      clock_source_in,
    output logic      reset_request_n_in,
    output logic      upper_address_test_pin,
    output logic      powerdown_delay_pin
);
    int   src_cnt    = 0;
    int   chg_cnt    = 0;
    logic src_reg    = 1'b0;
    logic charge_reg = 1'b0;

    // The double-rate source runs free; crystal_drive_out is left unconnected.
    always @(posedge clk)
    begin
        src_cnt <= (src_cnt == SRC_HALF - 1) ? 0 : src_cnt + 1;
        if (src_cnt == SRC_HALF - 1)
            src_reg <= #1 ~src_reg;
    end

    // The capacitor charges slowly and reads low again once charge_en drops.
    always @(posedge clk)
    begin
        chg_cnt    <= charge_en ? chg_cnt + 1 : 0;
        charge_reg <= #1 charge_en && (chg_cnt >= CHARGE);
    end

    assign clock_source_in        = src_reg;
    assign powerdown_delay_pin    = charge_reg;
    assign reset_request_n_in     = ~reset_cmd;
    assign upper_address_test_pin = ~test_mode_cmd;
endmodule : osc_reset_partner

// >>> test/clock_reset_pin_control_tb_top.sv
// Self-checking bench for the clock and reset pin control block.
// Assumes the design package and the partner model are compiled first.
`timescale 1ns/1ps

module clock_reset_pin_control_tb_top;
    localparam int SRC_HALF = 4;
    localparam int PD       = 2;

    logic                       clk;
    logic                       sys_rst;
    logic                       reset_cmd;
    logic                       test_mode_cmd;
    logic                       charge_en;
    logic                       idle_req;
    logic                       powerdown_req;
    logic                       wake_req;
    logic                       bus_cycle_active;
    logic                       clock_source_in;
    logic                       reset_request_n_in;
    logic                       upper_address_test_pin;
    logic                       powerdown_delay_pin;
    logic                       half_rate_clock_out;
    logic                       crystal_drive_out;
    logic                       crystal_drive_oe;
    logic                       reset_indication_out;
    logic                       pin_float_test_mode;
    logic                       bus_abort;
    logic                       powerdown_delay_oe;
    clock_reset_pkg::fetch_req_t fetch_req;
    clock_reset_pkg::clk_gate_t  clk_gate;
    int                         num_errors   = 0;
    int                         total_checks = 0;

    osc_reset_partner #(.SRC_HALF(SRC_HALF)) i_partner
    (
        .clk(clk), .reset_cmd(reset_cmd), .test_mode_cmd(test_mode_cmd),
        .charge_en(charge_en), .clock_source_in(clock_source_in),
        .reset_request_n_in(reset_request_n_in),
        .upper_address_test_pin(upper_address_test_pin),
        .powerdown_delay_pin(powerdown_delay_pin)
    );

    clock_reset_pin_control #(.PD_DELAY(PD)) i_dut
    (
        .clk(clk), .sys_rst(sys_rst), .clock_source_in(clock_source_in),
        .reset_request_n_in(reset_request_n_in),
        .upper_address_test_pin(upper_address_test_pin), .idle_req(idle_req),
        .powerdown_req(powerdown_req), .wake_req(wake_req),
        .powerdown_delay_pin(powerdown_delay_pin), .bus_cycle_active(bus_cycle_active),
        .half_rate_clock_out(half_rate_clock_out), .crystal_drive_out(crystal_drive_out),
        .crystal_drive_oe(crystal_drive_oe), .reset_indication_out(reset_indication_out),
        .pin_float_test_mode(pin_float_test_mode), .bus_abort(bus_abort),
        .powerdown_delay_oe(powerdown_delay_oe), .fetch_req(fetch_req), .clk_gate(clk_gate)
    );

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : finish_test

    task automatic check_bit(input logic got, input logic exp);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check_bit

    task automatic check_addr(input logic [19:0] got, input logic [19:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check_addr

    task automatic time_out();
        num_errors++;
        $display("mismatch at %0t: got %0h expected %0h", $time, 1'b0, 1'b1);
        finish_test();
    endtask : time_out

    // Counts the cycles for which the half-rate clock keeps level v.
    task automatic run_while(input logic v, output int cnt);
        cnt = 0;
        while (half_rate_clock_out === v)
        begin
            tick(1);
            cnt++;
            if (cnt > 100) time_out();
        end
    endtask : run_while

    task automatic wait_exec(output int cnt);
        cnt = 0;
        while (clk_gate.exec_clk_en !== 1'b1)
        begin
            tick(1);
            cnt++;
            if (cnt > 100) time_out();
        end
    endtask : wait_exec

    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask : pulse

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic do_reset(input logic test_low);
        int n;
        test_mode_cmd    = test_low;
        bus_cycle_active = 1'b1;
        reset_cmd        = 1'b1;
        tick(5);
        check_bit(reset_indication_out, 1'b1);
        check_bit(bus_abort, 1'b1);
        check_bit(powerdown_delay_oe, 1'b0);
        bus_cycle_active = 1'b0;
        repeat (20)
        begin
            tick(1);
            check_bit(reset_indication_out, 1'b1);
        end
        reset_cmd = 1'b0;
        n = 0;
        while (fetch_req.fetch_valid !== 1'b1)
        begin
            tick(1);
            n++;
            if (n > 100) time_out();
        end
        check_addr(fetch_req.fetch_addr, 20'hF_FFF0);
        check_bit(reset_indication_out, 1'b0);
        check_bit(half_rate_clock_out, 1'b0);
        check_bit(n > 3, 1'b1);
        check_bit(pin_float_test_mode, test_low);
        check_bit(crystal_drive_oe, 1'b1);
        tick(1);
        check_bit(fetch_req.fetch_valid, 1'b0);
        test_mode_cmd = 1'b0;
        $display("reset test done");
    endtask : do_reset

    task automatic test_half_clock();
        int hi;
        int lo;
        run_while(1'b1, hi);
        run_while(1'b0, lo);
        run_while(1'b1, hi);
        run_while(1'b0, lo);
        check_bit(hi == 2 * SRC_HALF, 1'b1);
        check_bit(hi + lo == 4 * SRC_HALF, 1'b1);
        $display("half clock test done");
    endtask : test_half_clock

    task automatic test_idle();
        int n;
        pulse(idle_req);
        tick(3);
        check_bit(clk_gate.exec_clk_en, 1'b0);
        check_bit(clk_gate.periph_clk_en, 1'b1);
        pulse(wake_req);
        wait_exec(n);
        check_bit(clk_gate.periph_clk_en, 1'b1);
        $display("idle test done");
    endtask : test_idle

    task automatic test_powerdown();
        int n;
        pulse(powerdown_req);
        tick(3);
        check_bit(|clk_gate, 1'b0);
        check_bit(crystal_drive_out, 1'b0);
        pulse(wake_req);
        tick(10);
        check_bit(clk_gate.exec_clk_en, 1'b0);
        charge_en = 1'b1;
        n = 0;
        while (powerdown_delay_pin !== 1'b1)
        begin
            tick(1);
            n++;
            if (n > 100) time_out();
        end
        wait_exec(n);
        check_bit(n >= PD, 1'b1);
        check_bit(n <= PD + 6, 1'b1);
        charge_en = 1'b0;
        $display("powerdown test done");
    endtask : test_powerdown

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial
    begin
        sys_rst          = 1'b1;
        reset_cmd        = 1'b0;
        test_mode_cmd    = 1'b0;
        charge_en        = 1'b0;
        idle_req         = 1'b0;
        powerdown_req    = 1'b0;
        wake_req         = 1'b0;
        bus_cycle_active = 1'b0;
        tick(3);
        sys_rst = 1'b0;
        do_reset(1'b0);
        test_half_clock();
        do_reset(1'b1);
        test_idle();
        test_powerdown();
        finish_test();
    end
endmodule : clock_reset_pin_control_tb_top
